// *** inc/sadc_pkg.sv ***
// Purpose: constants for the stereo converter serial output port
// Assumes: one core clock at 40 MHz is the digital section clock
// Notes: the analog modulators and filter arithmetic are outside
//
// Contract
// - analog clock halved for modulator rate; it runs at 128x word rate
// - divided clock output runs at 128x word rate, held high while either power-down high
// - analog section powered down while analog_powerdown high
// - digital powerdown high halts; release starts 4096-frame calibration
// - calibrate_flag rises at powerdown, falls 4096 frames after release
// - calibrate_source_select high routes modulators to zero-level inputs
// - role select high: device makes bit clock, window, channel clock
// - samples shifted MSB first in two's complement
// - tag bits follow each word: overload and channel identity
// - launch edge of bit clock is fixed per variant
// - master bit clock runs at 64x word rate, held low while either power-down high
// - slave: bits shift only while window high; MSB on channel edge
// - master channel clock toggles at word rate, one bit before window
// - master: left data while channel clock high, right while low
// - master: MSB appears one bit clock after channel clock change
// - slave: channel clock rising edge starts left MSB
// - left and right words of one frame sampled at same instant
// - master window rises with first bit, drops after last audio bit
// - output words forced to zero during calibration
// - measured offset stored per channel and subtracted afterwards
package sadc_pkg;
	localparam int SADC_WORD_BITS = 16;
	localparam int SADC_TAG_BITS = 2;
	localparam int SADC_CAL_FRAMES = 4096;
	localparam int SADC_BITS_PER_HALF = 32;
	localparam logic [7:0] SADC_DIV_RATIO_LO = 8'h02;
	localparam logic [7:0] SADC_DIV_RATIO_HI = 8'h03;
	localparam logic [15:0] SADC_ZERO_WORD = 16'h0000;
	localparam logic [15:0] SADC_POS_FULL = 16'h7FFF;
	localparam logic [15:0] SADC_NEG_FULL = 16'h8000;
endpackage : sadc_pkg

// *** hdl/sadc_sync.sv ***
// Purpose: two-stage synchroniser for a level input
// Assumes: destination clock is core_clk_i
// Notes: first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module sadc_sync (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// level
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			sync_o <= 1'b0;
		end else if (clk_en_i) begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : sadc_sync
`default_nettype wire

// *** hdl/sadc_port.sv ***
// Purpose: divider, power-down, calibration and serial output port
// Assumes: core_clk_i is the filter clock; slave pins are asynchronous
// Notes: samples arrive as one-cycle strobes from the decimator
`timescale 1ns/1ps
`default_nettype none
module sadc_port
	import sadc_pkg::*;
#(
	parameter int WORD_BITS = SADC_WORD_BITS,
	parameter int CAL_FRAMES = SADC_CAL_FRAMES,
	parameter bit LAUNCH_FALLING = 1'b0
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// configuration pins
	input wire logic clock_ratio_select_i,
	input wire logic port_role_select_i,
	input wire logic analog_powerdown_i,
	input wire logic digital_powerdown_i,
	input wire logic calibrate_source_select_i,
	// samples from the decimator
	input wire logic sample_valid_i,
	input wire logic [WORD_BITS-1:0] left_sample_i,
	input wire logic [WORD_BITS-1:0] right_sample_i,
	input wire logic left_overload_i,
	input wire logic right_overload_i,
	// analog section control
	output logic analog_enable_o,
	output logic modulator_zero_sel_o,
	output logic divided_clock_out_o,
	output logic calibrate_flag_o,
	// serial port pins, three signals each where two-way
	input wire logic serial_bit_clock_i,
	output logic serial_bit_clock_o,
	output logic serial_bit_clock_oe_o,
	input wire logic frame_window_i,
	output logic frame_window_o,
	output logic frame_window_oe_o,
	input wire logic channel_select_clock_i,
	output logic channel_select_clock_o,
	output logic channel_select_clock_oe_o,
	output logic serial_audio_out_o
);
	localparam int FRAME_BITS = WORD_BITS + SADC_TAG_BITS;

	typedef enum logic [2:0] {
		ST_DOWN = 3'b001,
		ST_CAL = 3'b010,
		ST_RUN = 3'b100
	} sadc_state_type;

	function automatic logic [WORD_BITS-1:0] sat_sub(
		input logic [WORD_BITS-1:0] a,
		input logic [WORD_BITS-1:0] b
	);
		logic [WORD_BITS:0] d;
		d = {a[WORD_BITS-1], a} - {b[WORD_BITS-1], b};
		if (d[WORD_BITS] != d[WORD_BITS-1])
			sat_sub = d[WORD_BITS] ? WORD_BITS'(SADC_NEG_FULL)
				: WORD_BITS'(SADC_POS_FULL);
		else
			sat_sub = d[WORD_BITS-1:0];
	endfunction : sat_sub

	// =====================================================
	// input synchronisers
	logic dpd_s, apd_s, calibrate_source_select_s, role_s, ratio_s, sclk_s, fwin_s, lr_s;
	sadc_sync u_dpd (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .async_i(digital_powerdown_i), .sync_o(dpd_s));
	sadc_sync u_apd (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .async_i(analog_powerdown_i), .sync_o(apd_s));
	sadc_sync u_calibrate_source_select (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .async_i(calibrate_source_select_i),
		.sync_o(calibrate_source_select_s));
	sadc_sync u_role (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .async_i(port_role_select_i), .sync_o(role_s));
	sadc_sync u_ratio (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .async_i(clock_ratio_select_i),
		.sync_o(ratio_s));
	sadc_sync u_sclk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .async_i(serial_bit_clock_i), .sync_o(sclk_s));
	sadc_sync u_fwin (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .async_i(frame_window_i), .sync_o(fwin_s));
	sadc_sync u_lr (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .async_i(channel_select_clock_i), .sync_o(lr_s));

	// =====================================================
	// analog section control
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			analog_enable_o <= 1'b0;
			modulator_zero_sel_o <= 1'b0;
		end else if (clk_en_i) begin
			analog_enable_o <= !apd_s;
			modulator_zero_sel_o <= calibrate_source_select_s;
		end
	end

	// =====================================================
	// rate dividers: 128x output, 64x bit clock, word rate
	// divided clock is 128x word rate; analog side halves it
	logic [1:0] pre_q;
	logic [6:0] phase_q;
	logic pre_tick;
	assign pre_tick = (pre_q == 2'(SADC_DIV_RATIO_LO - 8'h01) && !ratio_s)
		|| (pre_q == 2'(SADC_DIV_RATIO_HI - 8'h01) && ratio_s);

	// dividers are reset while either power-down is high
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_q <= 2'h0;
			phase_q <= 7'h00;
		end else if (clk_en_i) begin
			if (dpd_s || apd_s) begin
				pre_q <= 2'h0;
				phase_q <= 7'h00;
			end else if (pre_tick) begin
				pre_q <= 2'h0;
				phase_q <= phase_q + 7'h01;
			end else begin
				pre_q <= pre_q + 2'h1;
			end
		end
	end

	// 256x gives ratio 2, 384x ratio 3: output is 128x either way
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			divided_clock_out_o <= 1'b0;
		else if (clk_en_i)
			divided_clock_out_o <= (pre_q == 2'h0);
	end

	// master bit clock phase: one bit clock spans two 128x ticks
	logic m_sclk_rise, m_sclk_fall;
	assign m_sclk_rise = pre_tick && phase_q[0];
	assign m_sclk_fall = pre_tick && !phase_q[0];

	// =====================================================
	// calibration sequence
	sadc_state_type state_q;
	logic [12:0] cal_cnt_q;
	logic frame_tick;
	logic [WORD_BITS-1:0] off_l_q, off_r_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_DOWN;
			cal_cnt_q <= 13'h0000;
		end else if (clk_en_i) begin
			unique case (state_q)
				ST_DOWN: begin
					cal_cnt_q <= 13'h0000;
					if (!dpd_s)
						state_q <= ST_CAL;
				end
				ST_CAL: begin
					if (dpd_s)
						state_q <= ST_DOWN;
					else if (frame_tick) begin
						if (cal_cnt_q == 13'(CAL_FRAMES - 1))
							state_q <= ST_RUN;
						cal_cnt_q <= cal_cnt_q + 13'h0001;
					end
				end
				ST_RUN: begin
					if (dpd_s)
						state_q <= ST_DOWN;
				end
				default: state_q <= ST_DOWN;
			endcase
		end
	end

	// flag is set from the synchronised pin or from any state other than ST_RUN
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			calibrate_flag_o <= 1'b1;
		else if (clk_en_i)
			calibrate_flag_o <= dpd_s || (state_q != ST_RUN);
	end

	// last sample seen in calibration becomes the stored offset
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			off_l_q <= '0;
			off_r_q <= '0;
		end else if (clk_en_i && state_q == ST_CAL && sample_valid_i) begin
			off_l_q <= left_sample_i;
			off_r_q <= right_sample_i;
		end
	end

	// =====================================================
	// sample pair latch; both words from one strobe
	logic [FRAME_BITS-1:0] pair_l_q, pair_r_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pair_l_q <= '0;
			pair_r_q <= '0;
		end else if (clk_en_i && sample_valid_i) begin
			if (state_q == ST_RUN) begin
				pair_l_q <= {sat_sub(left_sample_i, off_l_q),
					left_overload_i, 1'b1};
				pair_r_q <= {sat_sub(right_sample_i, off_r_q),
					right_overload_i, 1'b0};
			end else begin
				pair_l_q <= {WORD_BITS'(SADC_ZERO_WORD), 2'b01};
				pair_r_q <= {WORD_BITS'(SADC_ZERO_WORD), 2'b00};
			end
		end
	end

	// =====================================================
	// port timing events, master or slave
	logic sclk_d_q, lr_d_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_d_q <= 1'b0;
			lr_d_q <= 1'b0;
		end else if (clk_en_i) begin
			sclk_d_q <= sclk_s;
			lr_d_q <= lr_s;
		end
	end

	logic s_launch, s_lr_edge, s_lr_rise;
	assign s_launch = LAUNCH_FALLING ? (sclk_d_q && !sclk_s)
		: (!sclk_d_q && sclk_s);
	assign s_lr_edge = lr_s != lr_d_q;
	assign s_lr_rise = lr_s && !lr_d_q;

	// master bit counter inside one channel half
	logic [4:0] bit_q;
	logic m_lr_q;
	logic m_launch, m_half_end;
	assign m_launch = LAUNCH_FALLING ? m_sclk_fall : m_sclk_rise;
	assign m_half_end = m_launch && bit_q == 5'(SADC_BITS_PER_HALF - 1);
	assign frame_tick = role_s ? (m_half_end && !m_lr_q) : s_lr_rise;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_q <= 5'h00;
			m_lr_q <= 1'b0;
		end else if (clk_en_i) begin
			if (dpd_s || apd_s) begin
				bit_q <= 5'h00;
				m_lr_q <= 1'b0;
			end else if (m_launch) begin
				bit_q <= bit_q + 5'h01;
				if (m_half_end)
					m_lr_q <= !m_lr_q;
			end
		end
	end

	// =====================================================
	// shifter
	logic [FRAME_BITS-1:0] shift_q;
	logic [FRAME_BITS-1:0] hold_r_q;
	logic [FRAME_BITS-1:0] next_word;
	logic [4:0] left_q;
	logic word_start, bit_step, sel_left;
	// master: word starts one bit after channel edge
	assign word_start = role_s ? (m_launch && bit_q == 5'h00)
		: s_lr_edge;
	assign bit_step = role_s ? m_launch : (s_launch && fwin_s);
	// channel high selects left
	assign sel_left = role_s ? m_lr_q : lr_s;
	// right word taken with its left word, not from a later strobe
	assign next_word = sel_left ? pair_l_q : hold_r_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= '0;
			hold_r_q <= '0;
			left_q <= 5'h00;
		end else if (clk_en_i) begin
			if (word_start) begin
				shift_q <= next_word;
				left_q <= 5'(FRAME_BITS);
				if (sel_left)
					hold_r_q <= pair_r_q;
			end else if (bit_step && left_q != 5'h00) begin
				shift_q <= {shift_q[FRAME_BITS-2:0], 1'b0};
				left_q <= left_q - 5'h01;
			end
		end
	end

	// =====================================================
	// pin drivers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_audio_out_o <= 1'b0;
			serial_bit_clock_o <= 1'b0;
			channel_select_clock_o <= 1'b0;
			frame_window_o <= 1'b0;
			serial_bit_clock_oe_o <= 1'b0;
			frame_window_oe_o <= 1'b0;
			channel_select_clock_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			// bits change only on launch events, clear of the sample edge
			if (word_start)
				serial_audio_out_o <= next_word[FRAME_BITS-1];
			else if (bit_step)
				serial_audio_out_o <= (left_q > 5'h01)
					? shift_q[FRAME_BITS-2] : 1'b0;
			serial_bit_clock_o <= phase_q[0];
			// edge on the launch ending the half, not on the sample edge
			channel_select_clock_o <= m_half_end ? !m_lr_q : m_lr_q;
			// window spans the audio bits only, not the tag
			frame_window_o <= role_s && (word_start
				|| left_q > 5'(SADC_TAG_BITS + 1)
				|| (left_q == 5'(SADC_TAG_BITS + 1) && !bit_step));
			serial_bit_clock_oe_o <= role_s;
			frame_window_oe_o <= role_s;
			channel_select_clock_oe_o <= role_s;
		end
	end

	// =====================================================
	// checks
	sequence pd_rise_s;
		$rose(dpd_s);
	endsequence

	chk_flag_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && dpd_s |=> calibrate_flag_o)
		else $error("calibrate flag not set in power-down");
	chk_cal_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == ST_CAL && sample_valid_i && clk_en_i
		|=> pair_l_q[FRAME_BITS-1:2] == '0)
		else $error("word not zero during calibration");
	chk_div_reset: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && (dpd_s || apd_s) |=> phase_q == 7'h00 && pre_q == 2'h0)
		else $error("divider ran in power-down");
	chk_oe_role: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i |=> frame_window_oe_o == $past(role_s))
		else $error("pin enable does not follow role");
	chk_analog_pd: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && apd_s |=> !analog_enable_o)
		else $error("analog enabled in power-down");
	chk_zero_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i |=> modulator_zero_sel_o == $past(calibrate_source_select_s))
		else $error("zero routing wrong");
	chk_run_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && state_q == ST_RUN && !dpd_s |=> !calibrate_flag_o)
		else $error("flag high while running");
	chk_pd_enter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(pd_rise_s and clk_en_i) |=> state_q == ST_DOWN)
		else $error("power-down not entered");
	chk_word_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && word_start |=> left_q == 5'(FRAME_BITS))
		else $error("word length wrong");
endmodule : sadc_port
`default_nettype wire

// *** bench/sadc_rx.sv ***
// Purpose: serial audio receiver standing beside the converter port
// Assumes: data launched on rising bit clock, taken on falling
// Notes: in slave role it supplies bit and channel clocks
`timescale 1ns/1ps
`default_nettype none
module sadc_rx (
	// role and resolved wires
	input wire logic master_i,
	input wire logic bclk_i,
	input wire logic lr_i,
	input wire logic win_i,
	input wire logic sd_i,
	// slave drive
	output logic bclk_o,
	output logic lr_o,
	output logic win_o,
	// captured units
	output logic [17:0] lw_o,
	output logic [17:0] rw_o,
	output int wbad_o
);
	// idle until the first channel edge, so a partial half is skipped
	int n = 1000;
	int k = 0;
	int off;
	logic plr = 1'b0;
	logic [17:0] sh = 18'h00000;
	initial begin
		bclk_o = 1'b0;
		lr_o = 1'b0;
		lw_o = 18'h00000;
		rw_o = 18'h00000;
		wbad_o = 0;
	end
	// =====================================
	// slave clocks
	// slow bit clock leaves margin for the port's pin synchronisers
	always #150 bclk_o = ~bclk_o;
	always @(posedge bclk_o) begin
		k <= (k == 31) ? 0 : k + 1;
		if (k == 31)
			lr_o <= ~lr_o;
	end
	assign win_o = 1'b1;
	// =====================================
	// capture
	always @(negedge bclk_i) begin
		off = master_i ? 1 : 0;
		if (lr_i !== plr)
			n = 0;
		plr = lr_i;
		if (n >= off && n < off + 18) begin
			sh = {sh[16:0], sd_i};
			if (master_i && win_i !== (n < off + 16))
				wbad_o++;
		end
		if (n == off + 17) begin
			if (lr_i)
				lw_o = sh;
			else
				rw_o = sh;
		end
		n++;
	end
endmodule : sadc_rx
`default_nettype wire

// *** bench/stereo_adc_serial_output_port_tb.sv ***
// Purpose: self-checking bench for the converter serial port
// Assumes: calibration shortened to 4 frames
// Notes: offsets taken are left -256, right +256
`timescale 1ns/1ps
`default_nettype none
module stereo_adc_serial_output_port_tb;
	import sadc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ratio = 1'b0;
	logic role = 1'b1;
	logic analog_powerdown = 1'b1;
	logic digital_powerdown = 1'b1;
	logic calibrate_source_select = 1'b0;
	logic sv = 1'b0;
	logic lov = 1'b0;
	logic [15:0] ls = 16'hFF00;
	logic [15:0] rs = 16'h0100;
	logic aen, zsel, dclk, cflag, bo, boe, wo, woe, lo, loe, sd;
	logic pb, pl, pw;
	logic [17:0] lw, rw;
	int wbad;
	int errors = 0;
	int compares = 0;
	wire bw;
	wire lrw;
	wire ww;
	assign bw = boe ? bo : pb;
	assign lrw = loe ? lo : pl;
	assign ww = woe ? wo : pw;
	always #12.5 clk = ~clk; // 256x at ratio low
	sadc_port #(.CAL_FRAMES(4)) u_dut (
		.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
		.clock_ratio_select_i(ratio), .port_role_select_i(role),
		.analog_powerdown_i(analog_powerdown), .digital_powerdown_i(digital_powerdown),
		.calibrate_source_select_i(calibrate_source_select), .sample_valid_i(sv),
		.left_sample_i(ls), .right_sample_i(rs),
		.left_overload_i(lov), .right_overload_i(lov),
		.analog_enable_o(aen), .modulator_zero_sel_o(zsel),
		.divided_clock_out_o(dclk), .calibrate_flag_o(cflag),
		.serial_bit_clock_i(bw), .serial_bit_clock_o(bo),
		.serial_bit_clock_oe_o(boe), .frame_window_i(ww),
		.frame_window_o(wo), .frame_window_oe_o(woe),
		.channel_select_clock_i(lrw), .channel_select_clock_o(lo),
		.channel_select_clock_oe_o(loe), .serial_audio_out_o(sd));
	sadc_rx u_rx (.master_i(role), .bclk_i(bw), .lr_i(lrw), .win_i(ww),
		.sd_i(sd), .bclk_o(pb), .lr_o(pl), .win_o(pw),
		.lw_o(lw), .rw_o(rw), .wbad_o(wbad));
	// one decimator strobe every 256 clocks, one word period at ratio low
	always begin
		repeat (255) @(posedge clk);
		#2 sv = 1'b1;
		@(posedge clk);
		#2 sv = 1'b0;
	end
	// =====================================
	// shared tasks
	task automatic close_out;
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(string nm, logic [17:0] e, logic [17:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(int c);
		repeat (c) @(posedge clk);
		#2;
	endtask : cyc
	task automatic rises(logic sel, int c, int e, string nm);
		int n;
		logic p, v;
		n = 0;
		p = 1'b0;
		repeat (c) begin
			@(posedge clk);
			#1 v = sel ? bw : dclk;
			if (v === 1'b1 && p === 1'b0)
				n++;
			p = v;
		end
		compares++;
		if (n < e - 1 || n > e + 1) begin
			errors++;
			$display("[ERR] %s exp %0d got %0d", nm, e, n);
		end
		#1;
	endtask : rises
	// =====================================
	// scenarios
	task automatic t_pins;
		chk("cal_flag", 18'h1, 18'(cflag));
		chk("analog_en", 18'h0, 18'(aen));
		analog_powerdown = 1'b0;
		cyc(4);
		chk("analog_en", 18'h1, 18'(aen));
		calibrate_source_select = 1'b1;
		cyc(4);
		chk("zero_sel", 18'h1, 18'(zsel));
		calibrate_source_select = 1'b0;
		cyc(4);
		chk("zero_sel", 18'h0, 18'(zsel));
	endtask : t_pins
	task automatic t_cal;
		digital_powerdown = 1'b0;
		cyc(532);
		chk("cal_left", 18'h00001, lw);
		chk("cal_right", 18'h00000, rw);
		chk("cal_flag", 18'h1, 18'(cflag));
		chk("roles_oe", 18'h7, 18'({boe, woe, loe}));
		cyc(896);
		chk("cal_flag", 18'h0, 18'(cflag));
	endtask : t_cal
	task automatic t_data(logic [15:0] l, logic [15:0] r, logic ov,
		logic [17:0] el, logic [17:0] er, int w);
		ls = l;
		rs = r;
		lov = ov;
		cyc(w);
		chk("left_word", el, lw);
		chk("right_word", er, rw);
	endtask : t_data
	task automatic t_slave;
		role = 1'b0;
		cyc(10);
		chk("roles_oe", 18'h0, 18'({boe, woe, loe}));
		// minus offset, saturation off; slave words
		t_data(16'h1234, 16'h0010, 1'b0, 18'h04CD1, 18'h3FC40, 1800);
		role = 1'b1;
	endtask : t_slave
	task automatic t_rate;
		cyc(600);
		rises(1'b0, 120, 60, "div_clk_lo");
		rises(1'b1, 400, 100, "bit_clk_lo");
		digital_powerdown = 1'b1;
		cyc(4);
		chk("cal_flag", 18'h1, 18'(cflag));
		rises(1'b1, 100, 0, "bit_clk_held");
		ratio = 1'b1;
		cyc(4);
		digital_powerdown = 1'b0;
		cyc(4);
		rises(1'b0, 120, 40, "div_clk_hi");
		rises(1'b1, 600, 100, "bit_clk_hi");
	endtask : t_rate
	// =====================================
	// main sequence and watchdog
	initial begin
		repeat (12) @(posedge clk);
		#2 rst_n = 1'b1;
		cyc(4);
		t_pins();
		t_cal();
		t_data(16'h1234, 16'h0010, 1'b0, 18'h04CD1, 18'h3FC40, 768);
		// both words clip at full scale
		t_data(16'h7FF0, 16'h8010, 1'b1, 18'h1FFFF, 18'h20002, 768);
		chk("window", 18'h0, 18'(wbad));
		t_slave();
		t_rate();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out();
	end
endmodule : stereo_adc_serial_output_port_tb
`default_nettype wire
